// ### common/clb_pkg.sv
// package for the codec loopback control block
// assumes one system clock and a byte-wide microport decoder upstream
//
// What this block does
// - loop enable set activates loopback; loop type bit picks the kind
// - loop enable clear disables all loops; loop type bit is ignored
// - enabled with type high: serial PCM input returned to PCM output, digitally
// - during digital loop the receive path to handset receiver keeps working
// - enabled with type low: microphone sample routed to speaker via A/D, D/A
// - during analog loop the transmit A/D path still feeds the PCM output
// - loopback control register at address 07h, writable, read returns written bits 3:2, other bits zero
`default_nettype none

package clb_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned SAMPLE_W  = 8;

	localparam logic [ADDR_W-1:0] LOOP_CTRL_ADDR  = 8'h07;
	localparam int unsigned       LOOP_TYPE_POS   = 3;
	localparam int unsigned       LOOP_EN_POS     = 2;
	localparam logic              LOOP_EN_RESET   = 1'h0;
	localparam logic              LOOP_TYPE_RESET = 1'h0;
	localparam logic [DATA_W-1:0] RDATA_RESET     = 8'h00;
	localparam logic [DATA_W-1:0] UNMAPPED_RDATA  = 8'h00;
	localparam logic [SAMPLE_W-1:0] SAMPLE_RESET  = 8'h00;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic loop_type;
		logic loop_en;
	} clb_ctrl_t;

	typedef struct packed {
		logic [SAMPLE_W-1:0] pcm_in;
		logic [SAMPLE_W-1:0] adc;
	} clb_samples_t;

	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_DIGITAL,
		MODE_ANALOG
	} clb_mode_t;

endpackage

`default_nettype wire

// ### src/clb_sample_reg.sv
// one sample-wide path register, loaded once per frame
// assumes load is a one-cycle pulse on the system clock
`default_nettype none

module clb_sample_reg
	import clb_pkg::*;
(
	// clock and reset
	input  wire logic                CLK_SYS,
	input  wire logic                RESET_N,
	// sample
	input  wire logic                load,
	input  wire logic [SAMPLE_W-1:0] d,
	output var  logic [SAMPLE_W-1:0] q
);

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			q <= SAMPLE_RESET;
		end else if (load) begin
			q <= d;
		end
	end

endmodule // clb_sample_reg

`default_nettype wire

// ### src/clb_loopback.sv
// loopback control: control register and sample routing between paths
// assumes register strobes and frame tick come from logic on CLK_SYS
`default_nettype none

module clb_loopback
	import clb_pkg::*;
(
	// clock and reset
	input  wire logic                CLK_SYS,
	input  wire logic                RESET_N,
	// register access from the microport decoder
	input  wire logic                REG_WR,
	input  wire logic                REG_RD,
	input  wire logic [ADDR_W-1:0]   REG_ADDR,
	input  wire logic [DATA_W-1:0]   REG_WDATA,
	output var  logic [DATA_W-1:0]   REG_RDATA,
	output var  logic                REG_RVALID,
	// frame timing and incoming samples
	input  wire logic                FRAME_TICK,
	input  wire logic [SAMPLE_W-1:0] PCM_IN_SAMPLE,
	input  wire logic [SAMPLE_W-1:0] ADC_SAMPLE,
	// outgoing samples
	output var  logic [SAMPLE_W-1:0] PCM_OUT_SAMPLE,
	output var  logic [SAMPLE_W-1:0] HANDSET_DAC_SAMPLE,
	output var  logic [SAMPLE_W-1:0] SPEAKER_DAC_SAMPLE,
	output var  logic                SAMPLE_VALID,
	// loop status
	output var  logic                LOOP_DIGITAL,
	output var  logic                LOOP_ANALOG
);

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	clb_ctrl_t ctrl_q;
	clb_ctrl_t wr_ctrl;
	logic      wr_hit;
	logic      rd_hit;

	assign wr_hit = REG_WR && (REG_ADDR == LOOP_CTRL_ADDR);
	assign rd_hit = REG_RD && (REG_ADDR == LOOP_CTRL_ADDR);

	always_comb begin
		wr_ctrl.loop_en   = REG_WDATA[LOOP_EN_POS];
		wr_ctrl.loop_type = REG_WDATA[LOOP_TYPE_POS];
	end

	// only the two defined bits are stored; the rest read as zero
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_q.loop_en   <= LOOP_EN_RESET;
			ctrl_q.loop_type <= LOOP_TYPE_RESET;
		end else if (wr_hit) begin
			ctrl_q.loop_en   <= wr_ctrl.loop_en;
			ctrl_q.loop_type <= wr_ctrl.loop_type;
		end
	end

	// ---------------------------------------------------------------
	// read-back
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] rdata_d;

	always_comb begin
		rdata_d                = UNMAPPED_RDATA;
		if (rd_hit) begin
			rdata_d[LOOP_EN_POS]   = ctrl_q.loop_en;
			rdata_d[LOOP_TYPE_POS] = ctrl_q.loop_type;
		end
	end

	// ---------------------------------------------------------------
	// read answer
	// ---------------------------------------------------------------
	// every read is answered, mapped or not, so the host never waits on it
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			REG_RDATA  <= RDATA_RESET;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RDATA  <= rdata_d;
			REG_RVALID <= REG_RD;
		end
	end

	// ---------------------------------------------------------------
	// mode decode
	// ---------------------------------------------------------------
	// the type bit is looked at only under loop enable, so a stale
	// type never picks a route while the loops are off
	clb_mode_t mode;

	always_comb begin
		mode = MODE_NORMAL;
		if (!ctrl_q.loop_en) begin
			mode = MODE_NORMAL;
		end else if (ctrl_q.loop_type) begin
			mode = MODE_DIGITAL;
		end else begin
			mode = MODE_ANALOG;
		end
	end

	// ---------------------------------------------------------------
	// loop status
	// ---------------------------------------------------------------
	logic loop_digital_d;
	logic loop_analog_d;

	always_comb begin
		loop_digital_d = 1'b0;
		loop_analog_d  = 1'b0;
		case (mode)
			MODE_NORMAL: begin
				loop_digital_d = 1'b0;
				loop_analog_d  = 1'b0;
			end
			MODE_DIGITAL: begin
				loop_digital_d = 1'b1;
				loop_analog_d  = 1'b0;
			end
			MODE_ANALOG: begin
				loop_digital_d = 1'b0;
				loop_analog_d  = 1'b1;
			end
			default: begin
				loop_digital_d = 1'b0;
				loop_analog_d  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			LOOP_DIGITAL <= 1'b0;
			LOOP_ANALOG  <= 1'b0;
		end else begin
			LOOP_DIGITAL <= loop_digital_d;
			LOOP_ANALOG  <= loop_analog_d;
		end
	end

	// ---------------------------------------------------------------
	// routing
	// ---------------------------------------------------------------
	// the mode is sampled on the frame tick, so a write mid-frame
	// never splits one sample between two routes
	clb_samples_t        in_s;
	logic [SAMPLE_W-1:0] pcm_out_d;
	logic [SAMPLE_W-1:0] handset_d;
	logic [SAMPLE_W-1:0] speaker_d;

	assign in_s.pcm_in = PCM_IN_SAMPLE;
	assign in_s.adc    = ADC_SAMPLE;

	always_comb begin
		pcm_out_d = in_s.adc;
		handset_d = in_s.pcm_in;
		speaker_d = in_s.pcm_in;
		case (mode)
			MODE_NORMAL: begin
				pcm_out_d = in_s.adc;
				handset_d = in_s.pcm_in;
				speaker_d = in_s.pcm_in;
			end
			MODE_DIGITAL: begin
				pcm_out_d = in_s.pcm_in;
				handset_d = in_s.pcm_in;
				speaker_d = in_s.pcm_in;
			end
			MODE_ANALOG: begin
				pcm_out_d = in_s.adc;
				handset_d = in_s.pcm_in;
				speaker_d = in_s.adc;
			end
			default: begin
				pcm_out_d = in_s.adc;
				handset_d = in_s.pcm_in;
				speaker_d = in_s.pcm_in;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// output path registers
	// ---------------------------------------------------------------
	clb_sample_reg u_pcm_out (
		.CLK_SYS (CLK_SYS),
		.RESET_N (RESET_N),
		.load    (FRAME_TICK),
		.d       (pcm_out_d),
		.q       (PCM_OUT_SAMPLE)
	);

	clb_sample_reg u_handset (
		.CLK_SYS (CLK_SYS),
		.RESET_N (RESET_N),
		.load    (FRAME_TICK),
		.d       (handset_d),
		.q       (HANDSET_DAC_SAMPLE)
	);

	clb_sample_reg u_speaker (
		.CLK_SYS (CLK_SYS),
		.RESET_N (RESET_N),
		.load    (FRAME_TICK),
		.d       (speaker_d),
		.q       (SPEAKER_DAC_SAMPLE)
	);

	// ---------------------------------------------------------------
	// sample valid
	// ---------------------------------------------------------------
	// marks the cycle in which all three outputs first carry the new frame
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			SAMPLE_VALID <= 1'b0;
		end else begin
			SAMPLE_VALID <= FRAME_TICK;
		end
	end

endmodule // clb_loopback

`default_nettype wire

// ### tb/clb_loopback_props.sv
// checker: register answers and sample routing of the loopback block
// assumes it is bound to the block's top-level ports
`default_nettype none
module clb_loopback_props
	import clb_pkg::*;
(
	// clock and reset
	input wire logic                CLK_SYS,
	input wire logic                RESET_N,
	// register reads
	input wire logic                REG_RD,
	input wire logic [ADDR_W-1:0]   REG_ADDR,
	input wire logic [DATA_W-1:0]   REG_RDATA,
	input wire logic                REG_RVALID,
	// samples and status
	input wire logic                FRAME_TICK,
	input wire logic [SAMPLE_W-1:0] PCM_IN_SAMPLE,
	input wire logic [SAMPLE_W-1:0] ADC_SAMPLE,
	input wire logic [SAMPLE_W-1:0] PCM_OUT_SAMPLE,
	input wire logic [SAMPLE_W-1:0] HANDSET_DAC_SAMPLE,
	input wire logic [SAMPLE_W-1:0] SPEAKER_DAC_SAMPLE,
	input wire logic                LOOP_DIGITAL,
	input wire logic                LOOP_ANALOG
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	// status lags the control bits by one edge, so route is judged after the tick
	rd_answer_a: assert property (REG_RD |=> REG_RVALID)
		else $error("read not answered");
	unmapped_zero_a: assert property (REG_RD && REG_ADDR != LOOP_CTRL_ADDR
		|=> REG_RDATA == UNMAPPED_RDATA) else $error("unmapped read not zero");
	loop_excl_a: assert property (!(LOOP_DIGITAL && LOOP_ANALOG))
		else $error("both loops active");
	digital_route_a: assert property (FRAME_TICK ##1 LOOP_DIGITAL
		|-> PCM_OUT_SAMPLE == $past(PCM_IN_SAMPLE)) else $error("digital loop route");
	normal_route_a: assert property (FRAME_TICK ##1 !LOOP_DIGITAL && !LOOP_ANALOG
		|-> PCM_OUT_SAMPLE == $past(ADC_SAMPLE)) else $error("normal route");
	analog_spk_a: assert property (FRAME_TICK ##1 LOOP_ANALOG
		|-> SPEAKER_DAC_SAMPLE == $past(ADC_SAMPLE)) else $error("analog loop route");
	analog_tx_a: assert property (FRAME_TICK ##1 LOOP_ANALOG
		|-> PCM_OUT_SAMPLE == $past(ADC_SAMPLE)) else $error("transmit path lost");
	handset_a: assert property (FRAME_TICK |=> HANDSET_DAC_SAMPLE == $past(PCM_IN_SAMPLE))
		else $error("handset path lost");
	cover property (FRAME_TICK ##1 LOOP_DIGITAL);
	cover property (FRAME_TICK ##1 LOOP_ANALOG);
	cover property (FRAME_TICK ##1 !LOOP_DIGITAL && !LOOP_ANALOG);
	cover property (REG_RD && REG_ADDR != LOOP_CTRL_ADDR);
endmodule // clb_loopback_props
bind clb_loopback clb_loopback_props props_u (
	.CLK_SYS            (CLK_SYS),
	.RESET_N            (RESET_N),
	.REG_RD             (REG_RD),
	.REG_ADDR           (REG_ADDR),
	.REG_RDATA          (REG_RDATA),
	.REG_RVALID         (REG_RVALID),
	.FRAME_TICK         (FRAME_TICK),
	.PCM_IN_SAMPLE      (PCM_IN_SAMPLE),
	.ADC_SAMPLE         (ADC_SAMPLE),
	.PCM_OUT_SAMPLE     (PCM_OUT_SAMPLE),
	.HANDSET_DAC_SAMPLE (HANDSET_DAC_SAMPLE),
	.SPEAKER_DAC_SAMPLE (SPEAKER_DAC_SAMPLE),
	.LOOP_DIGITAL       (LOOP_DIGITAL),
	.LOOP_ANALOG        (LOOP_ANALOG)
);
`default_nettype wire

// ### tb/clb_host.sv
// host model: register writes and reads, driven from the falling edge
// assumes the block answers a read exactly one cycle later
`default_nettype none
module clb_host
	import clb_pkg::*;
(
	// clock
	input  wire logic              CLK_SYS,
	// register strobes
	output var  logic              REG_WR,
	output var  logic              REG_RD,
	output var  logic [ADDR_W-1:0] REG_ADDR,
	output var  logic [DATA_W-1:0] REG_WDATA
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = '0;
	// released lines carry inverted values so stale data is never mistaken
	task automatic wr(input logic [7:0] a, d);
		@(negedge CLK_SYS);
		{REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, d};
		@(negedge CLK_SYS);
		{REG_WR, REG_ADDR, REG_WDATA} = {1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge CLK_SYS);
		{REG_RD, REG_ADDR} = {1'b1, a};
		@(negedge CLK_SYS);
		{REG_RD, REG_ADDR} = {1'b0, ~a};
	endtask
endmodule // clb_host
`default_nettype wire

// ### tb/tb.sv
// testbench: reset state, register access and routing in every mode
// assumes the host model drives all register strobes
`default_nettype none
module tb
	import clb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys = 1'b0, reset_n = 1'b0, tick = 1'b0;
	logic [7:0] pcm_in = 8'h00, adc = 8'h00, addr, wdata, rdata, pcm_out, hs, spk;
	logic       wr, rd, rvalid, valid, l_dig, l_ana;
	int         fail_count = 0, n_tests = 0;
	always #2 clk_sys = ~clk_sys;
	clb_host host_u (.CLK_SYS(clk_sys), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
		.REG_WDATA(wdata));
	clb_loopback dut_u (.CLK_SYS(clk_sys), .RESET_N(reset_n), .REG_WR(wr), .REG_RD(rd),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
		.FRAME_TICK(tick), .PCM_IN_SAMPLE(pcm_in), .ADC_SAMPLE(adc),
		.PCM_OUT_SAMPLE(pcm_out), .HANDSET_DAC_SAMPLE(hs), .SPEAKER_DAC_SAMPLE(spk),
		.SAMPLE_VALID(valid), .LOOP_DIGITAL(l_dig), .LOOP_ANALOG(l_ana));
	task automatic chk(input string nm, input logic [7:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	task automatic close_out;
		$display("checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic t_reset;
		host_u.rd(8'h07);
		chk("rvalid", {7'h00, rvalid}, 8'h01);
		chk("ctrl", rdata, 8'h00);
		host_u.rd(8'h06);
		chk("unmapped", rdata, 8'h00);
		chk("flags", {6'h00, l_dig, l_ana}, 8'h00);
		$display("reset test done");
	endtask
	// low bits set too: only bits 3:2 are stored
	task automatic t_modes;
		logic [7:0] w, p, a;
		for (int i = 0; i < 4; i++) begin
			w = {4'h0, 2'(i), 2'h3};
			p = 8'hA0 + 8'(i);
			a = 8'h50 + 8'(i);
			host_u.wr(8'h07, w);
			host_u.rd(8'h07);
			chk("readback", rdata, w & 8'h0C);
			@(negedge clk_sys);
			{tick, pcm_in, adc} = {1'b1, p, a};
			@(negedge clk_sys);
			{tick, pcm_in, adc} = {1'b0, ~p, ~a};
			chk("valid", {7'h00, valid}, 8'h01);
			chk("pcm out", pcm_out, i == 3 ? p : a);
			chk("speaker", spk, i == 1 ? a : p);
			chk("handset", hs, p);
			chk("flags", {6'h00, l_dig, l_ana}, {6'h00, i == 3, i == 1});
		end
		$display("mode test done");
	endtask
	// digital loop is stored here, so a badly decoded address would show
	task automatic t_refuse;
		host_u.wr(8'h06, 8'h00);
		host_u.rd(8'h07);
		chk("kept", rdata, 8'h0C);
		host_u.rd(8'h06);
		chk("unmapped rvalid", {7'h00, rvalid}, 8'h01);
		chk("unmapped data", rdata, 8'h00);
		@(negedge clk_sys);
		reset_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		reset_n = 1'b1;
		chk("flags after reset", {6'h00, l_dig, l_ana}, 8'h00);
		host_u.rd(8'h07);
		chk("ctrl after reset", rdata, 8'h00);
		$display("refuse and reset test done");
	endtask
	initial begin
		repeat (20) @(negedge clk_sys);
		reset_n = 1'b1;
		t_reset();
		t_modes();
		t_refuse();
		close_out();
	end
endmodule // tb
`default_nettype wire
